// ===== tb/tcav_far_model.sv
// Purpose: RAM read port and data-move engine standing at the far side
// Assumes: Block words are formed from the read address, no storage
// Notes:   Slow mode stretches every read to four cycles
`timescale 1ns/1ns
`default_nettype none
module tcav_far_model (
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 mem_req_i,
	input  wire tcav_pkg::tcav_mreq_t mem_i,
	output logic                      mem_ack_o,
	output logic      [31:0]          mem_rdata_o,
	input  wire logic                 param_valid_i,
	output logic                      xfer_done_o,
	input  wire logic                 slow_i,
	input  wire logic                 chain_i,
	input  wire logic                 per_transfer_irq_select_i
);
	import tcav_pkg::*;
	logic [1:0]  wcnt_q;  // Wait cycles spent on this read
	logic [1:0]  ph_q;    // Word index inside a block
	logic        first_q; // Still in the first block
	logic [1:0]  ecnt_q;  // Engine busy cycles
	logic [31:0] val;     // Word for the current address
	assign mem_ack_o = mem_req_i && (wcnt_q == (slow_i ? 2'd3 : 2'd0));
	// Idle bus shows the inverse, so a stale word cannot pass as fresh
	assign mem_rdata_o = mem_ack_o ? val : ~val;
	// Layout of a block: mode A and source, mode B and dest, counts
	always_comb begin
		case (ph_q)
			2'd0: val = {8'h11, mem_i.addr};
			2'd1: val = {chain_i & first_q, per_transfer_irq_select_i, 6'h0, mem_i.addr};
			default: val = {mem_i.addr[15:0], ~mem_i.addr[15:0]};
		endcase
		// Vector entry points at an aligned start inside the RAM window
		if (!mem_i.long_w) begin
			val = {16'h0, 16'hfc00 + {7'h0, mem_i.addr[7:0], 1'b0}};
		end
	end
	// Read progress; a vector read restarts the block walk
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wcnt_q <= 2'd0;
			ph_q <= 2'd0;
			first_q <= 1'b1;
		end else if (mem_ack_o) begin
			wcnt_q <= 2'd0;
			if (!mem_i.long_w) begin
				ph_q <= 2'd0;
				first_q <= 1'b1;
			end else begin
				ph_q <= (ph_q == 2'd2) ? 2'd0 : ph_q + 2'd1;
				if (ph_q == 2'd2) first_q <= 1'b0;
			end
		end else if (mem_req_i) begin
			wcnt_q <= wcnt_q + 2'd1;
		end
	end
	// Engine finishes each job after three busy cycles
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ecnt_q <= 2'd0;
			xfer_done_o <= 1'b0;
		end else begin
			xfer_done_o <= 1'b0;
			if (param_valid_i && !xfer_done_o) begin
				ecnt_q <= ecnt_q + 2'd1;
				if (ecnt_q == 2'd2) begin
					xfer_done_o <= 1'b1;
					ecnt_q <= 2'd0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== tb/transfer_ctrl_activation_vector_test.sv
// Purpose: Register-level test of the activation front end
// Assumes: Zero-wait slave, far side from tcav_far_model
// Notes:   Reads of the status word pace every activation scenario
`timescale 1ns/1ns
`default_nettype none
module transfer_ctrl_activation_vector_test;
	import tcav_pkg::*;
	logic clk_i, resetn_i, ce_i, hsel_i, hwrite_i, hready_i, hresp_o, hreadyout_o;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, mem_rdata_i;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [7:0] irq_i, cpu_irq_o, flag_clr_o;
	logic rxclr, swirq, swack, mreq, mack, pvalid, xdone, cdone, slow, chain, per_transfer_irq_select;
	tcav_mreq_t mem;
	tcav_param_t prm;
	logic [24:0] aq[$]; // Every read taken by the far side
	int err_count, compares, fc0, rxc;
	logic [31:0] v;
	assign hready_i = hreadyout_o;
	tcav_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
		.hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_i(irq_i), .cpu_irq_o(cpu_irq_o),
		.flag_clr_o(flag_clr_o), .receive_full_flag_clr_o(rxclr),
		.sw_transfer_end_irq_o(swirq), .sw_end_ack_i(swack), .mem_req_o(mreq),
		.mem_o(mem), .mem_ack_i(mack), .mem_rdata_i(mem_rdata_i), .param_valid_o(pvalid),
		.param_o(prm), .xfer_done_i(xdone), .count_done_i(cdone));
	tcav_far_model far (.clk_i(clk_i), .resetn_i(resetn_i), .mem_req_i(mreq), .mem_i(mem),
		.mem_ack_o(mack), .mem_rdata_o(mem_rdata_i), .param_valid_i(pvalid),
		.xfer_done_o(xdone), .slow_i(slow), .chain_i(chain), .per_transfer_irq_select_i(per_transfer_irq_select));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Watch reads and flag clears mid-cycle, away from the edge
	always @(negedge clk_i) begin
		if (mreq && mack) aq.push_back({mem.long_w, mem.addr});
		if (flag_clr_o[0]) fc0++;
		if (rxclr) rxc++;
	end
	// A cleared flag on source 0 or 6 drops its peripheral request
	always @(posedge clk_i) begin
		if (flag_clr_o[0]) irq_i[0] <= 1'b0;
		if (flag_clr_o[6]) irq_i[6] <= 1'b0;
	end
	task finish_test;
		$display("Counts: %0d mismatches in %0d compares", err_count, compares);
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("FAIL at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task tmo;
		err_count++;
		$display("FAIL at %0t: wait ran out, seen %h expected %h", $time, 0, 1);
		finish_test();
	endtask
	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 20);
		if (n >= 20) tmo();
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= 2'b10;
		rdy();
		htrans_i <= 2'b00;
		hsel_i <= 1'b0;
		hwdata_i <= d;
		rdy();
		v = hrdata_o;
	endtask
	task rdc(input logic [31:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v, e);
	endtask
	task idle;
		int n;
		repeat (3) @(posedge clk_i);
		n = 0;
		do begin
			bus(1'b0, OFF_STAT, 32'h0);
			n++;
		end while (v[2:0] !== 3'd0 && n < 200);
		if (n >= 200) tmo();
	endtask
	task ack;
		@(posedge clk_i);
		swack <= 1'b1;
		@(posedge clk_i);
		swack <= 1'b0;
	endtask
	initial begin
		{hsel_i, hwrite_i, swack, cdone, slow, chain, per_transfer_irq_select, err_count, compares} = '0;
		{haddr_i, hwdata_i, htrans_i, irq_i, fc0, rxc} = '0;
		hsize_i = 3'd2;
		ce_i = 1'b1;
		resetn_i = 1'b0;
		#360000 tmo();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		resetn_i <= 1'b1;
		rdc(OFF_SAV, {24'h0, SAV_RST});
		rdc(OFF_EN, {24'h0, EN_RST});
		rdc(32'h0c, 32'h0);
		chk(32'(hresp_o), 32'h0);
		bus(1'b1, OFF_SAV, 32'h10);
		rdc(OFF_SAV, 32'h10);
		chk(32'(aq.size()), 32'd0);
		per_transfer_irq_select <= 1'b1;
		bus(1'b1, OFF_SAV, 32'h90);
		bus(1'b1, OFF_SAV, 32'h85);
		rdc(OFF_SAV, 32'h90);
		idle();
		chk(32'(aq[0]), 32'h0000420);
		chk(32'(aq[1]), 32'h1fffc40);
		chk({prm.mode_reg_a, prm.source_addr_reg}, 32'h11fffc40);
		chk({prm.mode_reg_b, prm.dest_addr_reg}, 32'h40fffc44);
		chk({prm.count_reg_a, prm.count_reg_b}, 32'hfc4803b7);
		rdc(OFF_SAV, 32'h90);
		chk(32'(swirq), 32'h1);
		ack();
		rdc(OFF_SAV, 32'h10);
		chk(32'(swirq), 32'h0);
		per_transfer_irq_select <= 1'b0;
		bus(1'b1, OFF_SAV, 32'h90);
		idle();
		rdc(OFF_SAV, 32'h10);
		chk(32'(swirq), 32'h0);
		ce_i <= 1'b0;
		bus(1'b1, OFF_SAV, 32'h95);
		ce_i <= 1'b1;
		rdc(OFF_SAV, 32'h10);
		{chain, cdone, slow} <= 3'b111;
		aq.delete();
		bus(1'b1, OFF_SAV, 32'h81);
		idle();
		chk(32'(aq.size()), 32'd7);
		chk(32'(aq[4]), 32'h1fffc10);
		rdc(OFF_SAV, 32'h81);
		ack();
		{chain, cdone} <= 2'b00;
		aq.delete();
		bus(1'b1, OFF_EN, 32'h41);
		irq_i <= 8'h43;
		@(posedge clk_i);
		@(negedge clk_i);
		chk(32'(cpu_irq_o), 32'h02);
		repeat (300) if (rxc == 0) @(posedge clk_i);
		idle();
		chk(32'(aq[0]), 32'h0000420);
		chk(32'(aq[4]), 32'h00004b2);
		chk(fc0, 32'd1);
		chk(rxc, 32'd1);
		rdc(OFF_EN, 32'h41);
		cdone <= 1'b1;
		irq_i[0] <= 1'b1;
		idle();
		rdc(OFF_EN, 32'h40);
		chk(fc0, 32'd1);
		chk(32'(cpu_irq_o), 32'h03);
		finish_test();
	end
endmodule
`default_nettype wire

// ===== verilog/tcav_pkg.sv
// Purpose: Shared constants and types for the transfer activation front end
// Assumes: 24-bit on-chip address space, 32-bit register bus
// Notes:   Byte offsets below are the full byte addresses on the bus
`default_nettype none
package tcav_pkg;
	// Register byte offsets
	localparam logic [31:0] OFF_SAV  = 32'h0000_0000; // Software activation vector
	localparam logic [31:0] OFF_EN   = 32'h0000_0004; // Source activation enables
	localparam logic [31:0] OFF_STAT = 32'h0000_0008; // Engine status, read only
	// Reset values
	localparam logic [7:0]  SAV_RST  = 8'h00;
	localparam logic [7:0]  EN_RST   = 8'h00;
	// Field positions
	localparam int          SW_ACTIVATE_ENABLE_BIT = 7;  // Enable bit in vector register
	localparam int          CHAIN_ENABLE_BIT  = 7;  // Chain enable in mode B
	localparam int          PER_TRANSFER_IRQ_SELECT_BIT = 6;  // Per-transfer irq select in mode B
	// Source set and table
	localparam int          N_SRC    = 8;
	localparam int          SRC_RX0  = 6;   // Serial channel 0 receive source
	// Vector numbers, entry k in bits [7k+6:7k], entry 0 has top priority
	localparam logic [55:0] SRC_VEC  = {7'd90, 7'd89, 7'd40, 7'd38,
	                                    7'd19, 7'd18, 7'd17, 7'd16};
	localparam logic [15:0] VEC_BASE = 16'h0400; // Vector table base
	localparam logic [7:0]  VEC_HI   = 8'h00;    // Upper bits of table address
	localparam logic [7:0]  RAM_HI   = 8'hff;    // Upper bits of RAM window
	localparam logic [23:0] PB_STEP  = 24'h00000c; // Parameter block length
	// Front end states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_VEC  = 3'b001,
		ST_PB0  = 3'b010,
		ST_PB1  = 3'b011,
		ST_PB2  = 3'b100,
		ST_XFER = 3'b101,
		ST_END  = 3'b110
	} tcav_state_t;
	// Parameter block as read from RAM
	typedef struct packed {
		logic [7:0]  mode_reg_a;
		logic [23:0] source_addr_reg;
		logic [7:0]  mode_reg_b;
		logic [23:0] dest_addr_reg;
		logic [15:0] count_reg_a;
		logic [15:0] count_reg_b;
	} tcav_param_t;
	// Memory read request
	typedef struct packed {
		logic [23:0] addr;
		logic        long_w;  // 1: 32-bit read, 0: 16-bit read
	} tcav_mreq_t;
endpackage
`default_nettype wire

// ===== verilog/tcav_top.sv
// Purpose: Activation and vector-fetch front end of a transfer controller
// Assumes: Peripheral requests and engine handshakes are on clk_i
// Notes:   AHB-Lite slave with zero wait states, always OKAY
// Function
// - Writing enable one starts; zero ignored
// - Hardware clears enable on count pending
// - Enable stays set, end irq raised
// - Seven-bit vector field, all reset zero
// - Vector field writable only while enable clear
// - Vector address is 0x0400 plus twice
// - Start on enabled irq or write
// - Enable bit steers irq CPU or controller
// - At end clear flag or enable
// - Serial receive source clears receive-full flag
// - Mask level and priorities never gate
// - Simultaneous sources served in fixed order
// - Block fields read in fixed order
// - Read vector entry, then the block
// - Vector entry fetched as two bytes
// - Irq per transfer or at count end
// - Chain continues, skips end handling
`timescale 1ns/1ns
`default_nettype none
module tcav_top (
	input  wire logic                 clk_i,
	input  wire logic                 resetn_i,
	input  wire logic                 ce_i,
	// AHB-Lite slave
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic      [31:0]          hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	// Peripheral requests and routing
	input  wire logic [7:0]           irq_i,
	output logic      [7:0]           cpu_irq_o,
	output logic      [7:0]           flag_clr_o,
	output logic                      receive_full_flag_clr_o,
	output logic                      sw_transfer_end_irq_o,
	input  wire logic                 sw_end_ack_i,
	// On-chip RAM read port
	output logic                      mem_req_o,
	output tcav_pkg::tcav_mreq_t      mem_o,
	input  wire logic                 mem_ack_i,
	input  wire logic [31:0]          mem_rdata_i,
	// Data-move engine
	output logic                      param_valid_o,
	output tcav_pkg::tcav_param_t     param_o,
	input  wire logic                 xfer_done_i,
	input  wire logic                 count_done_i
);
	import tcav_pkg::*;

	tcav_state_t state_q;            // Front end state
	logic        sw_activate_enable_q;            // Software activation enable
	logic [6:0]  vec_q;              // Software vector number
	logic [7:0]  en_q;               // Source activation enables
	logic        sw_go_q;            // Software activation not yet taken
	logic        sw_irq_q;           // Software end interrupt pending
	logic        cur_sw_q;           // Current job came from software
	logic [2:0]  cur_src_q;          // Current hardware source
	logic [23:0] pb_addr_q;          // Current parameter block address
	logic [7:0]  flag_clr_q;         // Peripheral flag clear pulses
	tcav_param_t param_q;            // Captured parameter block
	tcav_mreq_t  mreq_q;             // Memory request address
	logic        ap_wr_q;            // Write data phase pending
	logic [31:0] ap_addr_q;          // Address of pending write
	logic [31:0] hrdata_q;           // Read data for data phase

	// Requests granted to the controller vs the CPU
	logic [7:0]  pend;
	assign pend      = irq_i & en_q & ~flag_clr_q; // A clear in flight blocks a retake
	// Once routed here, no mask or priority level is consulted
	assign cpu_irq_o = irq_i & ~en_q;

	// Fixed-priority pick, lowest index wins
	logic [2:0]  pick;
	logic        hw_any;
	always_comb begin
		pick   = 3'd0;
		hw_any = 1'b0;
		for (int k = N_SRC - 1; k >= 0; k--) begin
			if (pend[k]) begin
				pick   = 3'(k);
				hw_any = 1'b1;
			end
		end
	end

	// Vector table address per hardware source
	logic [15:0] src_vaddr [N_SRC];
	genvar g;
	generate
		for (g = 0; g < N_SRC; g++) begin : g_vec
			assign src_vaddr[g] = VEC_BASE + {8'h00, SRC_VEC[7*g+6 -: 7], 1'b0};
		end
	endgenerate
	logic [15:0] sw_vaddr;
	assign sw_vaddr = VEC_BASE + {8'h00, vec_q, 1'b0};

	// Bus decode: address phase qualifiers
	logic ap_take;
	logic wr_sav;
	logic wr_en;
	assign ap_take = hsel_i & htrans_i[1] & hready_i;
	assign wr_sav  = ap_wr_q & (ap_addr_q == OFF_SAV);
	assign wr_en   = ap_wr_q & (ap_addr_q == OFF_EN);

	// End-of-job decisions, taken only without chain
	logic chain_enable;
	logic per_transfer_irq_select;
	logic end_hit;
	logic keep_en;
	assign chain_enable    = param_q.mode_reg_b[CHAIN_ENABLE_BIT];
	assign per_transfer_irq_select   = param_q.mode_reg_b[PER_TRANSFER_IRQ_SELECT_BIT];
	assign end_hit = (state_q == ST_END) & ~chain_enable;
	assign keep_en = per_transfer_irq_select | count_done_i;

	// Bus pipeline: zero wait states, so every transfer ends in one cycle
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ap_wr_q   <= 1'b0;
			ap_addr_q <= 32'h0000_0000;
			hrdata_q  <= 32'h0000_0000;
		end else if (ce_i) begin
			ap_wr_q   <= ap_take & hwrite_i;
			ap_addr_q <= haddr_i;
			// Read data is formed at the address phase; unmapped reads 0
			if (ap_take & ~hwrite_i) begin
				case (haddr_i)
					OFF_SAV:  hrdata_q <= {24'h0, sw_activate_enable_q, vec_q};
					OFF_EN:   hrdata_q <= {24'h0, en_q};
					OFF_STAT: hrdata_q <= {24'h0, 2'b00, sw_irq_q,
					                       cur_sw_q, 1'b0, state_q};
					default:  hrdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign hrdata_o    = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// Software activation register
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sw_activate_enable_q <= SAV_RST[SW_ACTIVATE_ENABLE_BIT];
			vec_q   <= SAV_RST[6:0];
			sw_go_q <= 1'b0;
		end else if (ce_i) begin
			// Vector number changes only while enable is low
			if (wr_sav & ~sw_activate_enable_q)
				vec_q <= hwdata_i[6:0];
			// Hardware clear: count pending, or ack after end irq
			if ((end_hit & cur_sw_q & ~keep_en) | (sw_end_ack_i & sw_irq_q))
				sw_activate_enable_q <= 1'b0;
			// Only a one takes effect; a set wins over a clear
			if (wr_sav & hwdata_i[SW_ACTIVATE_ENABLE_BIT])
				sw_activate_enable_q <= 1'b1;
			// New activation only on a rising enable
			if (wr_sav & hwdata_i[SW_ACTIVATE_ENABLE_BIT] & ~sw_activate_enable_q)
				sw_go_q <= 1'b1;
			else if (state_q == ST_IDLE && sw_go_q)
				sw_go_q <= 1'b0;
		end
	end

	// Software end interrupt; enable stays set meanwhile
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			sw_irq_q <= 1'b0;
		else if (ce_i) begin
			if (sw_end_ack_i)
				sw_irq_q <= 1'b0;
			if (end_hit & cur_sw_q & keep_en)
				sw_irq_q <= 1'b1;
		end
	end
	assign sw_transfer_end_irq_o = sw_irq_q;

	// Source enables; hardware clear per source, bus write wins
	generate
		for (g = 0; g < N_SRC; g++) begin : g_en
			always_ff @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i)
					en_q[g] <= EN_RST[g];
				else if (ce_i) begin
					if (wr_en)
						en_q[g] <= hwdata_i[g];
					else if (end_hit & ~cur_sw_q & keep_en && cur_src_q == 3'(g))
						en_q[g] <= 1'b0; // Further requests go to the CPU
				end
			end
		end
	endgenerate

	// Peripheral flag clear pulse when the enable is kept
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i)
			flag_clr_q <= 8'h00;
		else if (ce_i) begin
			flag_clr_q <= 8'h00;
			if (end_hit & ~cur_sw_q & ~keep_en)
				flag_clr_q[cur_src_q] <= 1'b1;
		end
	end
	assign flag_clr_o              = flag_clr_q;
	assign receive_full_flag_clr_o = flag_clr_q[SRC_RX0];

	// Sequencer: vector entry, then block words, then the move
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q   <= ST_IDLE;
			cur_sw_q  <= 1'b0;
			cur_src_q <= 3'd0;
			pb_addr_q <= 24'h000000;
			mreq_q    <= '0;
			param_q   <= '0;
		end else if (ce_i) begin
			case (state_q)
				ST_IDLE: begin
					// Software outranks all hardware sources
					if (sw_go_q) begin
						state_q  <= ST_VEC;
						cur_sw_q <= 1'b1;
						mreq_q   <= '{addr: {VEC_HI, sw_vaddr}, long_w: 1'b0};
					end else if (hw_any) begin
						state_q   <= ST_VEC;
						cur_sw_q  <= 1'b0;
						cur_src_q <= pick;
						mreq_q    <= '{addr: {VEC_HI, src_vaddr[pick]}, long_w: 1'b0};
					end
				end
				ST_VEC: begin
					// Two-byte entry, upper bits from RAM window
					if (mem_ack_i) begin
						pb_addr_q <= {RAM_HI, mem_rdata_i[15:0]};
						mreq_q    <= '{addr: {RAM_HI, mem_rdata_i[15:0]}, long_w: 1'b1};
						state_q   <= ST_PB0;
					end
				end
				ST_PB0: begin
					// Mode A with source address
					if (mem_ack_i) begin
						param_q.mode_reg_a      <= mem_rdata_i[31:24];
						param_q.source_addr_reg <= mem_rdata_i[23:0];
						mreq_q.addr             <= pb_addr_q + 24'h000004;
						state_q                 <= ST_PB1;
					end
				end
				ST_PB1: begin
					// Mode B with destination address
					if (mem_ack_i) begin
						param_q.mode_reg_b    <= mem_rdata_i[31:24];
						param_q.dest_addr_reg <= mem_rdata_i[23:0];
						mreq_q.addr           <= pb_addr_q + 24'h000008;
						state_q               <= ST_PB2;
					end
				end
				ST_PB2: begin
					// Count A then count B
					if (mem_ack_i) begin
						param_q.count_reg_a <= mem_rdata_i[31:16];
						param_q.count_reg_b <= mem_rdata_i[15:0];
						state_q             <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (xfer_done_i)
						state_q <= ST_END;
				end
				ST_END: begin
					// Chain: next block directly follows
					if (chain_enable) begin
						pb_addr_q   <= pb_addr_q + PB_STEP;
						mreq_q.addr <= pb_addr_q + PB_STEP;
						state_q     <= ST_PB0;
					end else
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Request is a level while fetching; address is registered
	assign mem_req_o     = (state_q == ST_VEC) | (state_q == ST_PB0) |
	                       (state_q == ST_PB1) | (state_q == ST_PB2);
	assign mem_o         = mreq_q;
	assign param_valid_o = (state_q == ST_XFER);
	assign param_o       = param_q;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	chk_sw_set_wins: assert property (
		ce_i & wr_sav & hwdata_i[SW_ACTIVATE_ENABLE_BIT] |=> sw_activate_enable_q)
		else $error("enable not set by write of one");
	chk_vec_locked: assert property (
		ce_i & wr_sav & sw_activate_enable_q |=> $stable(vec_q))
		else $error("vector changed while enable set");
	chk_sw_vec_addr: assert property (
		state_q == ST_VEC && cur_sw_q |->
		mreq_q.addr == {VEC_HI, 16'h0400 + {8'h00, vec_q, 1'b0}} && !mreq_q.long_w)
		else $error("bad software vector address");
	chk_block_order: assert property (
		ce_i && state_q == ST_PB0 && mem_ack_i |=> state_q == ST_PB1
		##0 mreq_q.addr == pb_addr_q + 24'h000004)
		else $error("block words out of order");
	chk_steer_cpu: assert property (
		en_q[0] |-> !cpu_irq_o[0])
		else $error("enabled source reached the CPU");
	chk_sw_clear: assert property (
		ce_i & end_hit & cur_sw_q & ~keep_en & ~wr_sav |=> !sw_activate_enable_q)
		else $error("enable not cleared");
	chk_sw_keep: assert property (
		ce_i & end_hit & cur_sw_q & keep_en & ~sw_end_ack_i |=>
		sw_activate_enable_q && sw_transfer_end_irq_o)
		else $error("enable dropped or no end irq");
	chk_chain_skip: assert property (
		ce_i && state_q == ST_END && chain_enable |=> state_q == ST_PB0 && flag_clr_o == 8'h00)
		else $error("chain did not continue cleanly");
	chk_vector_first: assert property (
		ce_i && state_q == ST_IDLE && (sw_go_q || hw_any) |=> state_q == ST_VEC)
		else $error("activation skipped vector fetch");

	cov_sw_run: cover property (state_q == ST_END && cur_sw_q);
	cov_hw_run: cover property (state_q == ST_END && !cur_sw_q && !chain_enable);
	cov_chain:  cover property (state_q == ST_END && chain_enable);
endmodule
`default_nettype wire
